// ### core/urt_top.v
// Serial port with reload/capture/baud timer, register port and line pins
`include "urt_consts.vh"
`default_nettype none

module urt_top (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  input  wire       rxd_in,
  output reg        rxd_out,
  output reg        rxd_oe,
  output reg        txd,
  input  wire       tmr_a_ovf,
  input  wire       mode2_div32,
  input  wire       tmr_b_ext_pin,
  input  wire       tmr_b_count_pin,
  output reg        xmit_room,
  output reg        irq_serial,
  output reg        irq_timer
);
  localparam RX_IDLE = 2'h0;
  localparam RX_UART = 2'h1;
  localparam RX_SHFT = 2'h2;

  // ****************************************
  // State
  // ****************************************
  reg  [7:0]  serial_control_status_reg;
  reg  [7:0]  tmr_b_ctl_reg;
  reg  [15:0] tmr_b_count_reg;
  reg  [15:0] tmr_b_hold_reg;
  reg  [3:0]  tmr_b_pre_reg;
  reg         ext_prev_reg;
  reg         cnt_prev_reg;
  reg  [1:0]  div_reg;
  reg         tx_busy_reg;
  reg  [10:0] tx_sh_reg;
  reg  [3:0]  tx_bits_reg;
  reg  [3:0]  tx_tk_reg;
  reg         tx_done_reg;
  reg  [1:0]  rx_state_reg;
  reg  [10:0] rx_sh_reg;
  reg  [3:0]  rx_bits_reg;
  reg  [3:0]  rx_tk_reg;
  reg         rx_s0_reg;
  reg         rx_s1_reg;
  reg         rx_prev_reg;
  reg         rx_done_reg;
  reg         rb8_load_reg;
  reg         rb8_val_reg;
  reg  [7:0]  uart_data_port_reg;

  wire [1:0]  mode = serial_control_status_reg[`URT_SC_MHI:`URT_SC_MLO];
  wire        mode0 = (mode == `URT_MODE_SHIFT);
  wire        sm2 = serial_control_status_reg[`URT_SC_SM2];
  wire        ren = serial_control_status_reg[`URT_SC_REN];
  wire        tb8 = serial_control_status_reg[`URT_SC_TB8];
  wire        ri = serial_control_status_reg[`URT_SC_RI];
  wire        tx_from_tmr_b = tmr_b_ctl_reg[`URT_TC_TX_FROM_TMR_B];
  wire        rx_from_tmr_b = tmr_b_ctl_reg[`URT_TC_RCLK];
  wire        baud_mode = tx_from_tmr_b | rx_from_tmr_b;
  wire        tmr_b_ext_enable = tmr_b_ctl_reg[`URT_TC_EXEN];
  wire        tmr_b_capture_select = tmr_b_ctl_reg[`URT_TC_CAP];
  wire [3:0]  frame_bits = mode0 ? `URT_BITS_M0 :
                           (mode == `URT_MODE_8BIT) ? `URT_BITS_M1 : `URT_BITS_M23;
  wire        wr_serial_control_status = sfr_wr & (sfr_addr == `URT_SERIAL_CONTROL_STATUS_ADDR);
  wire        wr_tctl = sfr_wr & (sfr_addr == `URT_TCTL_ADDR);

  // ****************************************
  // Timer B
  // ****************************************
  wire ext_fall = ext_prev_reg & ~tmr_b_ext_pin;
  wire cnt_fall = cnt_prev_reg & ~tmr_b_count_pin;
  wire pre_tick = (tmr_b_pre_reg == `URT_PRE_LAST);
  // Baud mode counts every clock so the serial rate can reach useful speeds
  wire tmr_b_inc = tmr_b_ctl_reg[`URT_TC_RUN] &
                   (baud_mode ? 1'b1 : (tmr_b_ctl_reg[`URT_TC_CNT] ? cnt_fall : pre_tick));
  wire tmr_b_ovf = tmr_b_inc & (tmr_b_count_reg == 16'hffff);
  // External events are ignored while the timer paces the serial port
  wire ext_evt = ext_fall & tmr_b_ext_enable & ~baud_mode;
  wire set_tf = tmr_b_ovf & ~baud_mode;
  wire ext_evt_flag = ext_evt;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tmr_b_ctl_reg   <= `URT_REG_RESET;
      tmr_b_count_reg <= 16'h0000;
      tmr_b_hold_reg  <= 16'h0000;
      tmr_b_pre_reg   <= 4'h0;
      ext_prev_reg    <= 1'b1;
      cnt_prev_reg    <= 1'b1;
    end else begin
      ext_prev_reg  <= tmr_b_ext_pin;
      cnt_prev_reg  <= tmr_b_count_pin;
      tmr_b_pre_reg <= pre_tick ? 4'h0 : tmr_b_pre_reg + 4'h1;
      if (wr_tctl)
        tmr_b_ctl_reg <= sfr_wdata;
      // Hardware set wins over a software clear in the same cycle
      if (set_tf)
        tmr_b_ctl_reg[`URT_TC_TF] <= 1'b1;
      if (ext_evt_flag)
        tmr_b_ctl_reg[`URT_TC_EXF] <= 1'b1;
      if (tmr_b_ovf) begin
        if (baud_mode | ~tmr_b_capture_select)
          tmr_b_count_reg <= tmr_b_hold_reg;
        else
          tmr_b_count_reg <= 16'h0000;
      end else if (ext_evt & ~tmr_b_capture_select) begin
        tmr_b_count_reg <= tmr_b_hold_reg;
      end else if (tmr_b_inc) begin
        tmr_b_count_reg <= tmr_b_count_reg + 16'h0001;
      end
      if (ext_evt & tmr_b_capture_select)
        tmr_b_hold_reg <= tmr_b_count_reg;
      if (sfr_wr & (sfr_addr == `URT_CNT_LO_ADDR))
        tmr_b_count_reg[7:0] <= sfr_wdata;
      if (sfr_wr & (sfr_addr == `URT_CNT_HI_ADDR))
        tmr_b_count_reg[15:8] <= sfr_wdata;
      if (sfr_wr & (sfr_addr == `URT_HOLD_LO_ADDR))
        tmr_b_hold_reg[7:0] <= sfr_wdata;
      if (sfr_wr & (sfr_addr == `URT_HOLD_HI_ADDR))
        tmr_b_hold_reg[15:8] <= sfr_wdata;
    end
  end

  // ****************************************
  // Rate sources
  // ****************************************
  wire div_last = mode2_div32 ? (div_reg == `URT_DIV32_LAST) : (div_reg == `URT_DIV64_LAST);
  wire div_tick = div_last;
  wire tx_tick = (mode == `URT_MODE_9FIX) ? div_tick :
                 (tx_from_tmr_b ? tmr_b_ovf : tmr_a_ovf);
  wire rx_tick = (mode == `URT_MODE_9FIX) ? div_tick :
                 (rx_from_tmr_b ? tmr_b_ovf : tmr_a_ovf);

  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      div_reg <= 2'h0;
    else
      div_reg <= div_last ? 2'h0 : div_reg + 2'h1;
  end

  // ****************************************
  // Transmit path
  // ****************************************
  wire       buf_in_ready;
  wire       buf_valid;
  wire [7:0] buf_data;
  wire       tx_start = ~tx_busy_reg & buf_valid;

  urt_buf2 #(.W(8)) u_txbuf (
    .clk       (ref_clk),
    .rst       (rst),
    .in_valid  (sfr_wr & (sfr_addr == `URT_DATA_ADDR)),
    .in_ready  (buf_in_ready),
    .in_data   (sfr_wdata),
    .out_valid (buf_valid),
    .out_ready (tx_start),
    .out_data  (buf_data)
  );

  wire tx_step = mode0 ? (tx_tk_reg == `URT_PRE_LAST) :
                         (tx_tick & (tx_tk_reg == `URT_OVS_LAST));

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg   <= 11'h7ff;
      tx_bits_reg <= 4'h0;
      tx_tk_reg   <= 4'h0;
      tx_done_reg <= 1'b0;
    end else begin
      tx_done_reg <= 1'b0;
      if (tx_start) begin
        tx_busy_reg <= 1'b1;
        tx_bits_reg <= 4'h0;
        tx_tk_reg   <= 4'h0;
        // Stop, ninth (or the only stop sent in mode 1), data, start: sent from bit 0; mode 0 has no start or stop
        if (mode0)
          tx_sh_reg <= {3'h7, buf_data};
        else if (mode == `URT_MODE_8BIT)
          tx_sh_reg <= {2'h3, buf_data, 1'b0};
        else
          tx_sh_reg <= {1'b1, tb8, buf_data, 1'b0};
      end else if (tx_busy_reg) begin
        if (mode0 | tx_tick)
          tx_tk_reg <= tx_step ? 4'h0 : tx_tk_reg + 4'h1;
        if (tx_step) begin
          tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
          tx_bits_reg <= tx_bits_reg + 4'h1;
          if (tx_bits_reg == frame_bits - 4'h1) begin
            tx_busy_reg <= 1'b0;
            tx_done_reg <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Receive path
  // ****************************************
  wire       rx_fall = rx_prev_reg & ~rxd_in;
  wire       maj = (rx_s0_reg & rx_s1_reg) | (rx_s0_reg & rxd_in) | (rx_s1_reg & rxd_in);
  // At the stop sample the data sits at [10:3] in mode 1 and at [9:2] in nine-bit modes
  wire       rx_stop = maj;
  wire       rx_ninth = rx_sh_reg[10];
  wire       rx_last = (rx_bits_reg == frame_bits - 4'h1);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_state_reg       <= RX_IDLE;
      rx_sh_reg          <= 11'h7ff;
      rx_bits_reg        <= 4'h0;
      rx_tk_reg          <= 4'h0;
      rx_s0_reg          <= 1'b1;
      rx_s1_reg          <= 1'b1;
      rx_prev_reg        <= 1'b1;
      rx_done_reg        <= 1'b0;
      rb8_load_reg       <= 1'b0;
      rb8_val_reg        <= 1'b0;
      uart_data_port_reg <= 8'h00;
    end else begin
      rx_prev_reg  <= rxd_in;
      rx_done_reg  <= 1'b0;
      rb8_load_reg <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          rx_tk_reg   <= 4'h0;
          rx_bits_reg <= 4'h0;
          if (ren & ~mode0 & rx_fall)
            rx_state_reg <= RX_UART;
          // The done pulse reaches the flag a cycle late; without it a frame restarts
          else if (ren & mode0 & ~ri & ~tx_busy_reg & ~rx_done_reg)
            rx_state_reg <= RX_SHFT;
        end
        RX_UART: begin
          if (rx_tick) begin
            rx_tk_reg <= rx_tk_reg + 4'h1;
            if (rx_tk_reg == `URT_OVS_S0)
              rx_s0_reg <= rxd_in;
            if (rx_tk_reg == `URT_OVS_S1)
              rx_s1_reg <= rxd_in;
            if (rx_tk_reg == `URT_OVS_S2) begin
              // Majority of three samples rejects short glitches
              rx_sh_reg   <= {maj, rx_sh_reg[10:1]};
              rx_bits_reg <= rx_bits_reg + 4'h1;
              if ((rx_bits_reg == 4'h0) & maj) begin
                rx_state_reg <= RX_IDLE;
              end else if (rx_last) begin
                rx_state_reg <= RX_IDLE;
                if (mode == `URT_MODE_8BIT) begin
                  if (~sm2 | rx_stop) begin
                    uart_data_port_reg <= rx_sh_reg[10:3];
                    rx_done_reg        <= 1'b1;
                  end
                  rb8_load_reg <= ~sm2;
                  rb8_val_reg  <= rx_stop;
                end else if (~sm2 | rx_ninth) begin
                  uart_data_port_reg <= rx_sh_reg[9:2];
                  rx_done_reg        <= 1'b1;
                  rb8_load_reg       <= 1'b1;
                  rb8_val_reg        <= rx_ninth;
                end
              end
            end
          end
        end
        RX_SHFT: begin
          rx_tk_reg <= (rx_tk_reg == `URT_PRE_LAST) ? 4'h0 : rx_tk_reg + 4'h1;
          if (rx_tk_reg == `URT_M0_SAMPLE) begin
            rx_sh_reg   <= {rxd_in, rx_sh_reg[10:1]};
            rx_bits_reg <= rx_bits_reg + 4'h1;
          end
          if ((rx_tk_reg == `URT_PRE_LAST) & (rx_bits_reg == `URT_BITS_M0)) begin
            rx_state_reg       <= RX_IDLE;
            uart_data_port_reg <= rx_sh_reg[10:3];
            rx_done_reg        <= 1'b1;
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Serial control/status and register reads
  // ****************************************
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serial_control_status_reg <= `URT_REG_RESET;
      sfr_rdata                 <= 8'h00;
    end else begin
      if (wr_serial_control_status)
        serial_control_status_reg <= sfr_wdata;
      if (tx_done_reg)
        serial_control_status_reg[`URT_SC_TI] <= 1'b1;
      if (rx_done_reg)
        serial_control_status_reg[`URT_SC_RI] <= 1'b1;
      if (rb8_load_reg)
        serial_control_status_reg[`URT_SC_RB8] <= rb8_val_reg;
      if (sfr_rd) begin
        case (sfr_addr)
          `URT_SERIAL_CONTROL_STATUS_ADDR:    sfr_rdata <= serial_control_status_reg;
          `URT_DATA_ADDR:    sfr_rdata <= uart_data_port_reg;
          `URT_TCTL_ADDR:    sfr_rdata <= tmr_b_ctl_reg;
          `URT_HOLD_LO_ADDR: sfr_rdata <= tmr_b_hold_reg[7:0];
          `URT_HOLD_HI_ADDR: sfr_rdata <= tmr_b_hold_reg[15:8];
          `URT_CNT_LO_ADDR:  sfr_rdata <= tmr_b_count_reg[7:0];
          `URT_CNT_HI_ADDR:  sfr_rdata <= tmr_b_count_reg[15:8];
          default:           sfr_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Registered pins and requests
  // ****************************************
  wire m0_tx = tx_busy_reg & mode0;
  wire m0_rx = (rx_state_reg == RX_SHFT);
  wire m0_tk_hi = m0_tx ? (tx_tk_reg >= `URT_M0_LOW_END) : (rx_tk_reg >= `URT_M0_LOW_END);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txd        <= 1'b1;
      rxd_out    <= 1'b1;
      rxd_oe     <= 1'b0;
      xmit_room  <= 1'b0;
      irq_serial <= 1'b0;
      irq_timer  <= 1'b0;
    end else begin
      // Mode 0 puts the shift clock on the transmit pin and data on the receive pin
      if (mode0)
        txd <= (m0_tx | m0_rx) ? m0_tk_hi : 1'b1;
      else
        txd <= tx_busy_reg ? tx_sh_reg[0] : 1'b1;
      rxd_out    <= m0_tx ? tx_sh_reg[0] : 1'b1;
      rxd_oe     <= m0_tx;
      xmit_room  <= buf_in_ready;
      irq_serial <= serial_control_status_reg[`URT_SC_TI] |
                    serial_control_status_reg[`URT_SC_RI];
      irq_timer  <= tmr_b_ctl_reg[`URT_TC_TF] | tmr_b_ctl_reg[`URT_TC_EXF];
    end
  end

endmodule

`default_nettype wire

// ### core/urt_consts.vh
// Constants for the serial port with its reload/capture timer
`ifndef URT_CONSTS_VH
`define URT_CONSTS_VH

// ****************************************
// Register addresses
// ****************************************
`define URT_SERIAL_CONTROL_STATUS_ADDR     8'h98
`define URT_DATA_ADDR     8'h99
`define URT_TCTL_ADDR     8'hc8
`define URT_HOLD_LO_ADDR  8'hca
`define URT_HOLD_HI_ADDR  8'hcb
`define URT_CNT_LO_ADDR   8'hcc
`define URT_CNT_HI_ADDR   8'hcd
`define URT_REG_RESET     8'h00

// ****************************************
// Serial control/status fields
// ****************************************
`define URT_SC_RI    0
`define URT_SC_TI    1
`define URT_SC_RB8   2
`define URT_SC_TB8   3
`define URT_SC_REN   4
`define URT_SC_SM2   5
`define URT_SC_MLO   6
`define URT_SC_MHI   7
`define URT_MODE_SHIFT  2'h0
`define URT_MODE_8BIT   2'h1
`define URT_MODE_9FIX   2'h2
`define URT_MODE_9VAR   2'h3

// ****************************************
// Timer control fields
// ****************************************
`define URT_TC_CAP   0
`define URT_TC_CNT   1
`define URT_TC_RUN   2
`define URT_TC_EXEN  3
`define URT_TC_TX_FROM_TMR_B  4
`define URT_TC_RCLK  5
`define URT_TC_EXF   6
`define URT_TC_TF    7

// ****************************************
// Timing counts
// ****************************************
`define URT_PRE_LAST     4'hb
`define URT_M0_LOW_END   4'h6
`define URT_M0_SAMPLE    4'h9
`define URT_OVS_LAST     4'hf
`define URT_OVS_S0       4'h6
`define URT_OVS_S1       4'h7
`define URT_OVS_S2       4'h8
`define URT_DIV32_LAST   2'h1
`define URT_DIV64_LAST   2'h3
`define URT_BITS_M0      4'h8
`define URT_BITS_M1      4'ha
`define URT_BITS_M23     4'hb

`endif

// ### core/urt_buf2.v
// Two-entry buffer with valid/ready on both sides
`default_nettype none

module urt_buf2 #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg  [W-1:0] ent0_reg;
  reg  [W-1:0] ent1_reg;
  reg  [1:0]   cnt_reg;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = ent0_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ent0_reg <= {W{1'b0}};
      ent1_reg <= {W{1'b0}};
      cnt_reg  <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_reg == 2'h0)
            ent0_reg <= in_data;
          else
            ent1_reg <= in_data;
          cnt_reg <= cnt_reg + 2'h1;
        end
        2'b01: begin
          ent0_reg <= ent1_reg;
          cnt_reg  <= cnt_reg - 2'h1;
        end
        2'b11: begin
          // Entry count is unchanged; the head moves on
          if (cnt_reg == 2'h1) begin
            ent0_reg <= in_data;
          end else begin
            ent0_reg <= ent1_reg;
            ent1_reg <= in_data;
          end
        end
        default: begin
          cnt_reg <= cnt_reg;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### tb/urt_checker.sv
// Port-level checks on the serial port and its timer
`default_nettype none
module urt_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       txd,
  input wire logic       rxd_oe,
  input wire logic       irq_serial,
  input wire logic       irq_timer
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sc_sh;
  logic [1:0] sel_sh;
  // ****************************************
  // Shadows of software writes
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sc_sh <= 8'h00;
      sel_sh <= 2'h0;
    end else if (sfr_wr && sfr_addr == 8'h98) begin
      sc_sh <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == 8'hc8) begin
      sel_sh <= sfr_wdata[5:4];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Assertions
  // ****************************************
  chk_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (sfr_rd &&
    !(sfr_addr inside {8'h98, 8'h99, 8'hc8, [8'hca:8'hcd]}) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_sw_bits: assert property (sfr_rd && sfr_addr == 8'h98 |=> sfr_rdata[7:3] == sc_sh[7:3])
    else $error("software control bits changed by hardware");
  chk_irq_serial: assert property (sfr_rd && sfr_addr == 8'h98 |=> irq_serial == |sfr_rdata[1:0])
    else $error("serial request disagrees with flags");
  chk_irq_timer: assert property (sfr_rd && sfr_addr == 8'hc8 |=> irq_timer == |sfr_rdata[7:6])
    else $error("timer request disagrees with flags");
  chk_tf_baud: assert property (sfr_rd && sfr_addr == 8'hc8 && sel_sh != 2'h0 |=> !sfr_rdata[7])
    else $error("overflow flag set in baud mode");
  chk_bit_len: assert property (sc_sh[7:6] != 2'h0 && $fell(txd) |=> (!txd) [*8])
    else $error("low bit on line too short");
  chk_no_drive: assert property (sc_sh[7:6] != 2'h0 |-> !rxd_oe)
    else $error("receive pin driven outside shift mode");
  cov_tx_frame: cover property ($fell(txd) && sc_sh[7:6] != 2'h0);
  cov_irq_serial: cover property ($rose(irq_serial));
  cov_irq_timer: cover property ($rose(irq_timer));
endmodule
bind urt_top urt_checker u_urt_checker (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .txd(txd),
  .rxd_oe(rxd_oe), .irq_serial(irq_serial), .irq_timer(irq_timer));
`default_nettype wire

// ### tb/urt_remote.sv
// Remote serial device on the receive and transmit lines
`default_nettype none
module urt_remote (
  input  wire logic ref_clk,
  input  wire logic txd,
  input  wire logic rxd_out,
  input  wire logic rxd_oe,
  output var  logic rxd_line
);
  timeunit 1ns;
  timeprecision 1ns;
  int         bit_clks = 32;
  int         nbits    = 9;
  logic [8:0] got_q[$];
  logic [8:0] word;
  logic       stop_ok  = 1'b1;
  logic [7:0] m0_word;
  int         m0_cnt   = 0;
  initial rxd_line = 1'b1;
  // Low start, data LSB first, high stop; idle gap lets the port re-arm
  task automatic send(input logic [8:0] d);
    @(negedge ref_clk);
    rxd_line = 1'b0;
    repeat (bit_clks) @(negedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      rxd_line = d[i];
      repeat (bit_clks) @(negedge ref_clk);
    end
    rxd_line = 1'b1;
    repeat (2 * bit_clks) @(negedge ref_clk);
  endtask
  // Mid-bit sampling; a start shorter than half a bit is dropped
  always begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge ref_clk);
    if (txd === 1'b0) begin
      word = 9'h000;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_clks) @(posedge ref_clk);
        word[i] = txd;
      end
      repeat (bit_clks) @(posedge ref_clk);
      stop_ok = stop_ok & (txd === 1'b1);
      got_q.push_back(word);
    end
  end
  // Mode 0: data pin read half a clock after each rising shift clock
  always begin
    @(posedge txd);
    @(negedge ref_clk);
    if (rxd_oe === 1'b1) begin
      m0_word = {rxd_out, m0_word[7:1]};
      m0_cnt++;
    end
  end
endmodule
`default_nettype wire

// ### tb/uart_with_reload_timer_tb.sv
// Register-level bench for the serial port and reload timer
`default_nettype none
module uart_with_reload_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk   = 1'b0;
  logic       rst       = 1'b1;
  logic [7:0] sfr_addr  = 8'h00;
  logic       sfr_wr    = 1'b0;
  logic       sfr_rd    = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       ext_pin   = 1'b1;
  logic       a_ovf     = 1'b0;
  logic       div32     = 1'b1;
  logic       cnt_pin   = 1'b1;
  logic [7:0] sfr_rdata;
  logic       rxd_in;
  logic       txd;
  logic       rxd_out;
  logic       rxd_oe;
  logic       xmit_room;
  logic       irq_serial;
  logic       irq_timer;
  logic [7:0] v;
  int         mismatches = 0;
  int         checks     = 0;
  always #20 ref_clk = ~ref_clk;
  urt_top u_urt_top (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .tmr_a_ovf(a_ovf), .mode2_div32(div32),
    .tmr_b_ext_pin(ext_pin), .tmr_b_count_pin(cnt_pin), .xmit_room(xmit_room),
    .irq_serial(irq_serial), .irq_timer(irq_timer));
  urt_remote u_urt_remote (.ref_clk(ref_clk), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .rxd_line(rxd_in));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] m,
                         input logic [7:0] exp);
    rd(a);
    chk(what, {1'b0, exp}, {1'b0, v & m});
  endtask
  // Polls a flag; a flag that never comes ends the run
  task automatic wait_bit(input logic [7:0] a, input int b);
    int n;
    n = 0;
    v = 8'h00;
    while (v[b] !== 1'b1 && n < 2000) begin
      rd(a);
      n++;
    end
    if (v[b] !== 1'b1) begin
      mismatches++;
      $display("[FAIL] flag %h.%0d expected 1 seen 0", a, b);
      final_report();
    end
  endtask
  task automatic wait_q(input int cnt);
    int n;
    n = 0;
    while (u_urt_remote.got_q.size() < cnt && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    if (u_urt_remote.got_q.size() < cnt) begin
      mismatches++;
      $display("[FAIL] frames expected %0d seen %0d", cnt, u_urt_remote.got_q.size());
      final_report();
    end
  endtask
  task automatic pulse_ext();
    @(negedge ref_clk);
    ext_pin = 1'b0;
    repeat (3) @(negedge ref_clk);
    ext_pin = 1'b1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    chk_reg("control", 8'h98, 8'hff, 8'h00);
    chk_reg("timer control", 8'hc8, 8'hff, 8'h00);
    chk_reg("unmapped", 8'h55, 8'hff, 8'h00);
    chk("room", 9'h001, {8'h00, xmit_room});
    $display("test reset done");
    wr(8'h98, 8'h98);
    wr(8'h99, 8'ha5);
    wr(8'h99, 8'h3c);
    wait_q(2);
    chk("tx frame", 9'h1a5, u_urt_remote.got_q.pop_front());
    chk("tx frame", 9'h13c, u_urt_remote.got_q.pop_front());
    div32 = 1'b0;
    u_urt_remote.bit_clks = 64;
    wr(8'h99, 8'hc3);
    wait_q(1);
    chk("div64 frame", 9'h1c3, u_urt_remote.got_q.pop_front());
    div32 = 1'b1;
    u_urt_remote.bit_clks = 32;
    wait_bit(8'h98, 1);
    chk("serial irq", 9'h001, {8'h00, irq_serial});
    chk("stop bit", 9'h001, {8'h00, u_urt_remote.stop_ok});
    $display("test mode 2 transmit done");
    wr(8'h98, 8'h90);
    u_urt_remote.send(9'h13c);
    wait_bit(8'h98, 0);
    chk_reg("rx data", 8'h99, 8'hff, 8'h3c);
    chk_reg("rx ninth", 8'h98, 8'h04, 8'h04);
    wr(8'h98, 8'hb0);
    u_urt_remote.send(9'h055);
    chk_reg("filtered flag", 8'h98, 8'h01, 8'h00);
    u_urt_remote.send(9'h166);
    wait_bit(8'h98, 0);
    chk_reg("rx data", 8'h99, 8'hff, 8'h66);
    wr(8'h98, 8'h90);
    u_urt_remote.send(9'h111);
    u_urt_remote.send(9'h122);
    chk_reg("overrun data", 8'h99, 8'hff, 8'h22);
    $display("test mode 2 receive done");
    u_urt_remote.bit_clks = 16;
    u_urt_remote.nbits = 8;
    for (int i = 0; i < 4; i++)
      wr(8'hca + 8'(i), 8'hff);
    a_ovf = 1'b1;
    wr(8'hc8, 8'h24);
    wr(8'h98, 8'h50);
    wr(8'h99, 8'h96);
    u_urt_remote.send(9'h05a);
    wait_q(1);
    chk("mode 1 frame", 9'h096, u_urt_remote.got_q.pop_front());
    wait_bit(8'h98, 0);
    chk_reg("rx data", 8'h99, 8'hff, 8'h5a);
    chk_reg("rx stop", 8'h98, 8'h04, 8'h04);
    chk_reg("baud ovf flag", 8'hc8, 8'h80, 8'h00);
    wr(8'h98, 8'h70);
    u_urt_remote.nbits = 9;
    u_urt_remote.send(9'h0a5);
    chk_reg("bad stop flag", 8'h98, 8'h01, 8'h00);
    u_urt_remote.nbits = 8;
    $display("test mode 1 baud done");
    wr(8'h98, 8'h00);
    wr(8'h99, 8'h5a);
    wait_bit(8'h98, 1);
    chk("mode 0 data", 9'h05a, {1'b0, u_urt_remote.m0_word});
    chk("mode 0 shifts", 9'h008, 9'(u_urt_remote.m0_cnt));
    wr(8'h98, 8'h10);
    wait_bit(8'h98, 0);
    chk_reg("mode 0 rx", 8'h99, 8'hff, 8'hff);
    $display("test mode 0 done");
    wr(8'hc8, 8'h00);
    for (int i = 0; i < 4; i++)
      wr(8'hca + 8'(i), 8'(i[0] ? 8'hff : 8'hf0));
    wr(8'hc8, 8'h04);
    wait_bit(8'hc8, 7);
    chk_reg("reloaded high", 8'hcd, 8'hff, 8'hff);
    chk("timer irq", 9'h001, {8'h00, irq_timer});
    wr(8'hc8, 8'h0c);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    pulse_ext();
    chk_reg("early reload", 8'hcd, 8'hff, 8'hff);
    chk_reg("ext flag", 8'hc8, 8'hc0, 8'h40);
    wr(8'hc8, 8'h0d);
    wr(8'hcd, 8'h12);
    wr(8'hcc, 8'h34);
    pulse_ext();
    chk_reg("hold high", 8'hcb, 8'hff, 8'h12);
    chk_reg("hold low", 8'hca, 8'hfe, 8'h34);
    chk_reg("ext flag", 8'hc8, 8'h40, 8'h40);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hf0);
    wait_bit(8'hc8, 7);
    chk_reg("capture rollover", 8'hcd, 8'hff, 8'h00);
    $display("test timer done");
    final_report();
  end
endmodule
`default_nettype wire
